/* coeff_decoder.sv */
// Rebuilds signed scaled coefficients from the committed profile
`include "lf_defines.svh"

module coeff_decoder (
    input logic pclk,
    input logic presetn,
    coeff_if.dec cif
);

    // ======================================================================
    // Helpers
    // ======================================================================
    // Alpha power: front + back - bias - right shift
    function automatic lf_pkg::scale_exp_t alpha_pow(input logic [2:0] f, input logic [3:0] b,
        input logic [5:0] r);
        int t;
        t = int'(f) + int'(b) - `LF_ALPHA_BIAS - int'(r);
        return t[7:0];
    endfunction

    // Negative power for the mantissa-exponent pairs
    function automatic lf_pkg::scale_exp_t neg_pow(input int bias, input logic [4:0] e);
        int t;
        t = -(bias + int'(e));
        return t[7:0];
    endfunction

    // Stored magnitude becomes a negative coefficient
    function automatic lf_pkg::coeff_mant_t negate(input logic [16:0] m);
        return -$signed({1'b0, m});
    endfunction

    // ======================================================================
    // Output registers, refreshed every cycle from the committed profile
    // ======================================================================
    // Active only changes on commit, so free-running refresh is glitch-free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cif.alpha_mant <= `LF_ALPHA_MANT_RST;
            cif.alpha_exp <= 8'hf0;
            cif.beta_coef <= 18'h3ffff;
            cif.beta_exp <= 8'hef;
            cif.gamma_coef <= 18'h3ffff;
            cif.gamma_exp <= 8'hef;
            cif.delta_mant <= `LF_DELTA_MANT_RST;
            cif.delta_exp <= 8'hf1;
        end else begin
            cif.alpha_mant <= cif.active.alpha_mant;
            cif.alpha_exp <= alpha_pow(cif.active.alpha_front, cif.active.alpha_back,
                cif.active.alpha_rshift);
            cif.beta_coef <= negate(cif.active.beta_mant);
            cif.beta_exp <= neg_pow(`LF_BETA_BIAS, cif.active.beta_exp);
            cif.gamma_coef <= negate(cif.active.gamma_mant);
            cif.gamma_exp <= neg_pow(`LF_GAMMA_BIAS, cif.active.gamma_exp);
            cif.delta_mant <= cif.active.delta_mant;
            cif.delta_exp <= neg_pow(`LF_DELTA_BIAS, cif.active.delta_exp);
        end
    end

    // Update strobe lags the commit by the one register stage above
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cif.update <= 1'b0;
        end else begin
            cif.update <= cif.load;
        end
    end

    // ======================================================================
    // Checks
    // ======================================================================
    beta_negated_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 cif.beta_coef == -$signed({1'b0, $past(cif.active.beta_mant)}))
        else $error("beta not negated");
    gamma_negated_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 cif.gamma_coef == -$signed({1'b0, $past(cif.active.gamma_mant)}))
        else $error("gamma not negated");
    alpha_power_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (int'(cif.alpha_exp) == int'($past(cif.active.alpha_front))
        + int'($past(cif.active.alpha_back)) - 16 - int'($past(cif.active.alpha_rshift))))
        else $error("alpha power wrong");
    beta_power_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 int'(cif.beta_exp) == -(17 + int'($past(cif.active.beta_exp))))
        else $error("beta power wrong");
    gamma_power_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 int'(cif.gamma_exp) == -(17 + int'($past(cif.active.gamma_exp))))
        else $error("gamma power wrong");
    delta_power_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 int'(cif.delta_exp) == -(15 + int'($past(cif.active.delta_exp))))
        else $error("delta power wrong");

endmodule

/* coeff_if.sv */
// Carrier between the register block and the coefficient decoder
interface coeff_if;
    lf_pkg::coeff_fields_t active;   // Committed profile
    logic load;                      // Pulse: profile just committed
    logic [15:0] alpha_mant;         // Rebuilt alpha mantissa
    lf_pkg::scale_exp_t alpha_exp;   // Alpha power of two
    lf_pkg::coeff_mant_t beta_coef;  // Negated beta mantissa
    lf_pkg::scale_exp_t beta_exp;    // Beta power of two
    lf_pkg::coeff_mant_t gamma_coef; // Negated gamma mantissa
    lf_pkg::scale_exp_t gamma_exp;   // Gamma power of two
    logic [14:0] delta_mant;         // Delta mantissa
    lf_pkg::scale_exp_t delta_exp;   // Delta power of two
    logic update;                    // Pulse: decoded set refreshed

    // Register side drives the profile, reads the results
    modport ctrl (output active, load, input alpha_mant, alpha_exp, beta_coef, beta_exp,
        gamma_coef, gamma_exp, delta_mant, delta_exp, update);
    // Decoder side reads the profile, drives the results
    modport dec (input active, load, output alpha_mant, alpha_exp, beta_coef, beta_exp,
        gamma_coef, gamma_exp, delta_mant, delta_exp, update);
endinterface

/* lf_defines.svh */
// Register map, field positions, reset values and scaling constants of the coefficient block
`ifndef LF_DEFINES_SVH
`define LF_DEFINES_SVH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define LF_CTRL_OFS 8'h00
`define LF_ALPHA_MANT_OFS 8'h04
`define LF_ALPHA_SCALE_OFS 8'h08
`define LF_BETA_OFS 8'h0c
`define LF_GAMMA_OFS 8'h10
`define LF_DELTA_OFS 8'h14
`define LF_STATUS_OFS 8'h18

// ==========================================================================
// Field positions
// ==========================================================================
`define LF_APPLY_BIT 0
`define LF_RSHIFT_LSB 0
`define LF_FRONT_LSB 8
`define LF_BACK_LSB 16
`define LF_MANT_LSB 0
`define LF_EXP_LSB 24
`define LF_PENDING_BIT 0
`define LF_COUNT_LSB 8

// ==========================================================================
// Reset values (smallest legal mantissa, no scaling)
// ==========================================================================
`define LF_ALPHA_MANT_RST 16'h0001
`define LF_BETA_MANT_RST 17'h00001
`define LF_GAMMA_MANT_RST 17'h00001
`define LF_DELTA_MANT_RST 15'h0001
`define LF_EXP_RST 5'h00

// ==========================================================================
// Scaling constants
// ==========================================================================
`define LF_ALPHA_BIAS 16
`define LF_BETA_BIAS 17
`define LF_GAMMA_BIAS 17
`define LF_DELTA_BIAS 15
`define LF_GAIN_MAX 5'h16
`define LF_FRONT_MAX 3'h7

`endif

/* lf_pkg.sv */
// Types shared by the coefficient register block and its decoder
package lf_pkg;

    // ======================================================================
    // Stored coefficient fields, one profile
    // ======================================================================
    typedef struct packed {
        logic [15:0] alpha_mant;   // Alpha linear part
        logic [5:0] alpha_rshift;  // Alpha right shift
        logic [2:0] alpha_front;   // Alpha front-end gain
        logic [3:0] alpha_back;    // Alpha back-end gain
        logic [16:0] beta_mant;    // Beta magnitude mantissa
        logic [4:0] beta_exp;      // Beta exponent
        logic [16:0] gamma_mant;   // Gamma magnitude mantissa
        logic [4:0] gamma_exp;     // Gamma exponent
        logic [14:0] delta_mant;   // Delta mantissa
        logic [4:0] delta_exp;     // Delta exponent
    } coeff_fields_t;

    // Signed power-of-two exponent handed to the filter core
    typedef logic signed [7:0] scale_exp_t;

    // Signed coefficient mantissa handed to the filter core
    typedef logic signed [17:0] coeff_mant_t;

endpackage

/* loop_filter_coeff_quantizer.sv */
// APB register block holding and committing the four loop filter coefficients
//
// Operation
// - Beta and gamma applied as negative coefficients
// - Fields limited to width, mantissa never zero
// - Alpha = mantissa * 2^(front+back-16-shift)
// - Beta = mantissa * 2^-(17+exponent)
// - Gamma = mantissa * 2^-(17+exponent)
// - Delta = mantissa * 2^-(15+exponent)
//
// Register access over APB and the register addresses were left to the implementer.
`include "lf_defines.svh"

module loop_filter_coeff_quantizer #(
    parameter int ADDR_W = 8  // APB address width
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [ADDR_W-1:0] paddr,
    input logic [31:0] pwdata,
    input logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [15:0] alpha_mant,
    output lf_pkg::scale_exp_t alpha_exp,
    output lf_pkg::coeff_mant_t beta_coef,
    output lf_pkg::scale_exp_t beta_exp,
    output lf_pkg::coeff_mant_t gamma_coef,
    output lf_pkg::scale_exp_t gamma_exp,
    output logic [14:0] delta_mant,
    output lf_pkg::scale_exp_t delta_exp,
    output logic coeff_update
);

    // ======================================================================
    // Constants and state
    // ======================================================================
    localparam lf_pkg::coeff_fields_t COEFF_RST = '{
        alpha_mant: `LF_ALPHA_MANT_RST, alpha_rshift: 6'h00, alpha_front: 3'h0,
        alpha_back: 4'h0, beta_mant: `LF_BETA_MANT_RST, beta_exp: `LF_EXP_RST,
        gamma_mant: `LF_GAMMA_MANT_RST, gamma_exp: `LF_EXP_RST,
        delta_mant: `LF_DELTA_MANT_RST, delta_exp: `LF_EXP_RST};

    lf_pkg::coeff_fields_t shadow_r;  // Software-visible staging copy
    lf_pkg::coeff_fields_t active_r;  // Copy the filter core uses
    logic load_r;                     // Commit pulse
    logic pending_r;                  // Staging written since last commit
    logic [7:0] commit_cnt_r;         // Commits since reset, wraps
    logic pready_r;                   // Access-phase ready
    logic pslverr_r;                  // Access-phase error
    logic [31:0] prdata_r;            // Read data register
    logic [7:0] ofs;                  // Word-aligned offset
    logic setup;                      // Setup phase seen
    logic wr;                         // Write accepted this edge
    logic [31:0] wimg;                // Write data merged with old image
    logic [15:0] a_mant_c;            // Clamped alpha mantissa
    logic [16:0] b_mant_c;            // Clamped beta mantissa
    logic [16:0] g_mant_c;            // Clamped gamma mantissa
    logic [14:0] d_mant_c;            // Clamped delta mantissa
    logic [2:0] front_c;              // Written front gain
    logic [3:0] back_c;               // Back gain after total limit

    coeff_if cif ();

    // ======================================================================
    // Helpers
    // ======================================================================
    // Offsets that answer without error
    function automatic logic addr_ok(input logic [7:0] a);
        case (a)
            `LF_CTRL_OFS, `LF_ALPHA_MANT_OFS, `LF_ALPHA_SCALE_OFS, `LF_BETA_OFS,
            `LF_GAMMA_OFS, `LF_DELTA_OFS, `LF_STATUS_OFS: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Register image of the staging copy and status
    function automatic logic [31:0] reg_image(input logic [7:0] a,
        input lf_pkg::coeff_fields_t f, input logic pend, input logic [7:0] cnt);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            `LF_ALPHA_MANT_OFS: v[`LF_MANT_LSB +: 16] = f.alpha_mant;
            `LF_ALPHA_SCALE_OFS: begin
                v[`LF_RSHIFT_LSB +: 6] = f.alpha_rshift;
                v[`LF_FRONT_LSB +: 3] = f.alpha_front;
                v[`LF_BACK_LSB +: 4] = f.alpha_back;
            end
            `LF_BETA_OFS: begin
                v[`LF_MANT_LSB +: 17] = f.beta_mant;
                v[`LF_EXP_LSB +: 5] = f.beta_exp;
            end
            `LF_GAMMA_OFS: begin
                v[`LF_MANT_LSB +: 17] = f.gamma_mant;
                v[`LF_EXP_LSB +: 5] = f.gamma_exp;
            end
            `LF_DELTA_OFS: begin
                v[`LF_MANT_LSB +: 15] = f.delta_mant;
                v[`LF_EXP_LSB +: 5] = f.delta_exp;
            end
            `LF_STATUS_OFS: begin
                v[`LF_PENDING_BIT] = pend;
                v[`LF_COUNT_LSB +: 8] = cnt;
            end
            default: v = 32'h0000_0000;  // Control reads as zero
        endcase
        return v;
    endfunction

    // Byte-lane merge under the write strobes
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] strb);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                v[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return v;
    endfunction

    // Zero mantissa would silence a path; lift it to one
    function automatic logic [16:0] lift_zero(input logic [16:0] m);
        return (m == 17'h00000) ? 17'h00001 : m;
    endfunction

    // ======================================================================
    // Bus decode and write data shaping
    // ======================================================================
    always_comb begin
        ofs = {paddr[7:2], 2'b00};
        setup = psel & ~penable;
        wr = psel & penable & pready_r & pwrite & ~pslverr_r;
        wimg = lane_merge(reg_image(ofs, shadow_r, pending_r, commit_cnt_r), pwdata, pstrb);
        a_mant_c = 16'(lift_zero({1'b0, wimg[`LF_MANT_LSB +: 16]}));
        b_mant_c = lift_zero(wimg[`LF_MANT_LSB +: 17]);
        g_mant_c = lift_zero(wimg[`LF_MANT_LSB +: 17]);
        d_mant_c = 15'(lift_zero({2'b00, wimg[`LF_MANT_LSB +: 15]}));
        front_c = wimg[`LF_FRONT_LSB +: 3];
        back_c = wimg[`LF_BACK_LSB +: 4];
        // Total gain may not pass its ceiling; back gain gives way
        if ({2'b00, front_c} + {1'b0, back_c} > `LF_GAIN_MAX) begin
            back_c = 4'(`LF_GAIN_MAX - {2'b00, front_c});
        end
    end

    // ======================================================================
    // APB answer: zero wait states, registered ready, error and data
    // ======================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup & ~addr_ok(ofs);
            if (setup & ~pwrite) begin
                // Sampled in setup; nothing else writes before the access edge
                prdata_r <= reg_image(ofs, shadow_r, pending_r, commit_cnt_r);
            end else if (!psel) begin
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    // ======================================================================
    // Staging copy, written field by field
    // ======================================================================
    // Magnitudes only; sign of beta and gamma is fixed by hardware
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_r <= COEFF_RST;
        end else if (wr) begin
            case (ofs)
                `LF_ALPHA_MANT_OFS: shadow_r.alpha_mant <= a_mant_c;
                `LF_ALPHA_SCALE_OFS: begin
                    shadow_r.alpha_rshift <= wimg[`LF_RSHIFT_LSB +: 6];
                    shadow_r.alpha_front <= front_c;
                    shadow_r.alpha_back <= back_c;
                end
                `LF_BETA_OFS: begin
                    shadow_r.beta_mant <= b_mant_c;
                    shadow_r.beta_exp <= wimg[`LF_EXP_LSB +: 5];
                end
                `LF_GAMMA_OFS: begin
                    shadow_r.gamma_mant <= g_mant_c;
                    shadow_r.gamma_exp <= wimg[`LF_EXP_LSB +: 5];
                end
                `LF_DELTA_OFS: begin
                    shadow_r.delta_mant <= d_mant_c;
                    shadow_r.delta_exp <= wimg[`LF_EXP_LSB +: 5];
                end
                default: shadow_r <= shadow_r;  // Control and status hold
            endcase
        end
    end

    // ======================================================================
    // Commit: whole profile moves at one edge
    // ======================================================================
    // Writing the staging copy never disturbs the running filter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_r <= COEFF_RST;
            load_r <= 1'b0;
        end else begin
            load_r <= wr && ofs == `LF_CTRL_OFS && wimg[`LF_APPLY_BIT];
            if (wr && ofs == `LF_CTRL_OFS && wimg[`LF_APPLY_BIT]) begin
                active_r <= shadow_r;
            end
        end
    end

    // Status: pending flag and commit counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending_r <= 1'b0;
            commit_cnt_r <= 8'h00;
        end else if (wr) begin
            if (ofs == `LF_CTRL_OFS && wimg[`LF_APPLY_BIT]) begin
                pending_r <= 1'b0;
                commit_cnt_r <= commit_cnt_r + 8'h01;
            end else if (ofs != `LF_CTRL_OFS && ofs != `LF_STATUS_OFS) begin
                pending_r <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Decoder and outputs
    // ======================================================================
    assign cif.active = active_r;
    assign cif.load = load_r;

    coeff_decoder u_dec (
        .pclk(pclk),
        .presetn(presetn),
        .cif(cif)
    );

    // Decoder outputs are its own flip-flops
    assign alpha_mant = cif.alpha_mant;
    assign alpha_exp = cif.alpha_exp;
    assign beta_coef = cif.beta_coef;
    assign beta_exp = cif.beta_exp;
    assign gamma_coef = cif.gamma_coef;
    assign gamma_exp = cif.gamma_exp;
    assign delta_mant = cif.delta_mant;
    assign delta_exp = cif.delta_exp;
    assign coeff_update = cif.update;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // ======================================================================
    // Checks
    // ======================================================================
    mant_nonzero_a: assert property (@(posedge pclk) disable iff (!presetn)
        active_r.alpha_mant != 0 && active_r.beta_mant != 0 && active_r.gamma_mant != 0
        && active_r.delta_mant != 0) else $error("zero mantissa committed");
    gain_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
        int'(shadow_r.alpha_front) + int'(shadow_r.alpha_back) <= 22)
        else $error("total gain above limit");
    profile_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr && ofs == `LF_CTRL_OFS && wimg[`LF_APPLY_BIT]) |=> $stable(active_r))
        else $error("profile changed without commit");
    profile_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && ofs == `LF_CTRL_OFS && wimg[`LF_APPLY_BIT]) |=> active_r == $past(shadow_r)
        ##1 coeff_update) else $error("commit not whole or not announced");
    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready && (pslverr == !addr_ok($past(ofs))))
        else $error("apb answer late or wrong");
    commit_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
        load_r ##2 coeff_update == 1'b0);
    read_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && !pwrite);
    error_seen_c: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);

endmodule

/* tb.sv */
// Self-checking bench for the loop filter coefficient register block
`include "lf_defines.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ======================================================================
    // Stimulus and observed signals
    // ======================================================================
    logic pclk = 1'b0; // 125 MHz system clock
    logic presetn = 1'b0; // Active low reset
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf; // Full words only
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] alpha_mant;
    lf_pkg::scale_exp_t alpha_exp, beta_exp, gamma_exp, delta_exp;
    lf_pkg::coeff_mant_t beta_coef, gamma_coef;
    logic [14:0] delta_mant;
    logic coeff_update;
    int fails = 0; // Mismatches
    int n_checks = 0; // Comparisons
    int n_commits = 0; // Commits issued, for the status counter
    // All decoded outputs in one word, for the hold check
    wire [127:0] dec_all = {29'h0, alpha_mant, alpha_exp, beta_coef, beta_exp,
        gamma_coef, gamma_exp, delta_mant, delta_exp};

    // Period 8 ns
    always #4 pclk = ~pclk;

    loop_filter_coeff_quantizer #(.ADDR_W(8)) i_loop_filter_coeff_quantizer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .alpha_mant(alpha_mant), .alpha_exp(alpha_exp), .beta_coef(beta_coef),
        .beta_exp(beta_exp), .gamma_coef(gamma_coef), .gamma_exp(gamma_exp),
        .delta_mant(delta_mant), .delta_exp(delta_exp), .coeff_update(coeff_update));

    // ======================================================================
    // Shared tasks
    // ======================================================================
    // Single compare point
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Verdict, also reached by any timeout
    task automatic report_and_stop;
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One APB transfer; waits for pready but never forever
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic er);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (pready !== 1'b1) begin
            fails++;
            report_and_stop();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Write that must not be refused
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, 32'h0);
    endtask

    // ======================================================================
    // Scenarios
    // ======================================================================
    // Decoded values straight after reset
    task automatic reset_values;
        chk(32'(alpha_mant), 32'h1);
        chk(32'(alpha_exp), -32'sh10);
        chk(32'(beta_coef), -32'sh1);
        chk(32'(beta_exp), -32'sh11);
        chk(32'(gamma_coef), -32'sh1);
        chk(32'(delta_exp), -32'shf);
    endtask

    // Stage a whole profile, commit it, check every decoded output
    task automatic load_commit(input logic [15:0] am, input logic [5:0] rs,
        input logic [2:0] fr, input logic [3:0] bk, input logic [16:0] bm,
        input logic [4:0] be, input logic [16:0] gm, input logic [4:0] ge,
        input logic [14:0] dm, input logic [4:0] de);
        logic [127:0] held;
        logic [31:0] r;
        logic e;
        int i;
        held = dec_all;
        wr(`LF_ALPHA_MANT_OFS, {16'h0, am});
        wr(`LF_ALPHA_SCALE_OFS, {12'h0, bk, 5'h0, fr, 2'h0, rs});
        wr(`LF_BETA_OFS, {3'h0, be, 7'h0, bm});
        wr(`LF_GAMMA_OFS, {3'h0, ge, 7'h0, gm});
        wr(`LF_DELTA_OFS, {3'h0, de, 9'h0, dm});
        // Staged but not committed: outputs must not move
        for (i = 0; i < 4; i++) chk(dec_all[i*32 +: 32], held[i*32 +: 32]);
        // Staging reads back; pending raised, counter not yet moved
        apb(1'b0, `LF_BETA_OFS, 32'h0, r, e);
        chk(r, {3'h0, be, 7'h0, (bm == 17'h0) ? 17'h1 : bm});
        apb(1'b0, `LF_STATUS_OFS, 32'h0, r, e);
        chk(r, {16'h0, 8'(n_commits), 8'h01});
        wr(`LF_CTRL_OFS, 32'h1);
        n_commits++;
        i = 0;
        while (coeff_update !== 1'b1 && i < 8) begin
            @(posedge pclk);
            i++;
        end
        if (coeff_update !== 1'b1) begin
            fails++;
            report_and_stop();
        end
        chk(32'(alpha_mant), 32'((am == 16'h0) ? 16'h1 : am));
        chk(32'(alpha_exp), 32'(int'(fr) + int'(bk) - 16 - int'(rs)));
        chk(32'(beta_coef), -32'((bm == 17'h0) ? 17'h1 : bm));
        chk(32'(beta_exp), 32'(-(17 + int'(be))));
        chk(32'(gamma_coef), -32'((gm == 17'h0) ? 17'h1 : gm));
        chk(32'(gamma_exp), 32'(-(17 + int'(ge))));
        chk(32'(delta_mant), 32'((dm == 15'h0) ? 15'h1 : dm));
        chk(32'(delta_exp), 32'(-(15 + int'(de))));
        @(posedge pclk);
        chk({31'h0, coeff_update}, 32'h0);
        apb(1'b0, `LF_STATUS_OFS, 32'h0, r, e);
        chk(r, {16'h0, 8'(n_commits), 8'h00});
    endtask

    // Unmapped word is refused and reads zero
    task automatic unmapped;
        logic [31:0] r;
        logic e;
        apb(1'b0, 8'h1c, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
    endtask

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        reset_values();
        // Worked example profile, then the field limits with zero alpha and beta mantissas
        load_commit(16'hd0a8, 6'h06, 3'h0, 4'h0, 17'h1250b, 5'h0d, 17'h13abb, 5'h0d,
            15'h420a, 5'h08);
        load_commit(16'h0, 6'h3f, 3'h7, 4'hf, 17'h0, 5'h1f, 17'h1ffff, 5'h1f, 15'h7fff, 5'h1f);
        unmapped();
        report_and_stop();
    end
endmodule
